//--- pkg/uadp_defines.vh
// register map, field positions, reset values and timing constants for the uart data path
// Function
// - receive buffer is a sixteen-byte FIFO
// - receiver timed by 16x clock, framing per line control
// - receive shifter assembles character, pushes to buffer
// - char mode: rx interrupt when data available and enabled
// - char mode: rx interrupt clears on buffer read
// - fifo mode: rx interrupt at fifo control trigger level; neither interrupt clears on data access
// - eight-bit scratch register, no side effects
// - transmit holding is a sixteen-byte FIFO
// - transmitter timed by baud clock, format per line control
// - load shifter from holding only when idle
// - transmit shifter serializes onto serial output
// - char mode: tx interrupt when holding empty and enabled
// - char mode: tx interrupt clears on holding load
// - baud divisor 1..65535 gives 16x clock
// - divisor byte write reloads baud counter immediately
`ifndef UADP_DEFINES_VH
`define UADP_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UADP_ADDR_DATA    4'h0
`define UADP_ADDR_INT_EN  4'h1
`define UADP_ADDR_FIFO    4'h2
`define UADP_ADDR_LINE    4'h3
`define UADP_ADDR_DIV_LO  4'h4
`define UADP_ADDR_DIV_HI  4'h5
`define UADP_ADDR_STATUS  4'h6
`define UADP_ADDR_SCRATCH 4'h7
`define UADP_ADDR_INT_ST  4'h8
`define UADP_ADDR_INT_MSK 4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UADP_IE_RX        0
`define UADP_IE_TX        1
`define UADP_FC_ENABLE    0
`define UADP_FC_RX_LVL_LO 6
`define UADP_FC_RX_LVL_HI 7
`define UADP_LC_WLEN_LO   0
`define UADP_LC_WLEN_HI   1
`define UADP_LC_STOP      2
`define UADP_LC_PAR_EN    3
`define UADP_LC_PAR_EVEN  4
`define UADP_ST_RX_AVAIL  0
`define UADP_ST_TX_EMPTY  5
`define UADP_ST_TEMT      6

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define UADP_LINE_RESET   8'h03
`define UADP_DIV_RESET    16'h0001
`define UADP_FIFO_DEPTH   16
`define UADP_PTR_W        4
`define UADP_CNT_W        5
`define UADP_OVS          4'hF
`define UADP_OVS_MID      4'h7

`endif

//--- hw/uadp_fifo.v
// sixteen-entry byte FIFO used for both holding and receive buffers
`include "uadp_defines.vh"

module uadp_fifo (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_flush,
  input  wire       i_push,
  input  wire [7:0] i_data,
  input  wire       i_pop,
  output wire [7:0] o_data,
  output wire [4:0] o_count
);
  reg  [7:0] mem [0:`UADP_FIFO_DEPTH-1];
  reg  [3:0] wr_q;
  reg  [3:0] rd_q;
  reg  [4:0] cnt_q;
  wire       do_push;
  wire       do_pop;

  // a push to a full store is dropped rather than overwriting
  assign do_push = i_push && (cnt_q != 5'h10);
  assign do_pop  = i_pop && (cnt_q != 5'h00);
  assign o_data  = mem[rd_q];
  assign o_count = cnt_q;

  always @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_q] <= i_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_reset || i_flush) begin
      wr_q  <= 4'h0;
      rd_q  <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 4'h1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 4'h1;
      end
      cnt_q <= cnt_q + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
endmodule

//--- hw/uadp_top.v
// uart transmit and receive data path with baud generator and register port
`include "uadp_defines.vh"

module uadp_top (
  input  wire       I_MCLK,
  input  wire       I_RESET,
  input  wire [3:0] I_ADDR,
  input  wire [7:0] I_WDATA,
  input  wire       I_WR,
  input  wire       I_RD,
  input  wire       I_RX_CLK16,
  input  wire       I_SERIAL_INPUT,
  output reg  [7:0] O_RDATA,
  output reg        O_SERIAL_OUTPUT,
  output reg        O_BAUD_CLOCK_OUT,
  output reg        O_IRQ
);
  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  localparam [3:0] TX_IDLE  = 4'b0001;
  localparam [3:0] TX_START = 4'b0010;
  localparam [3:0] TX_DATA  = 4'b0100;
  localparam [3:0] TX_STOP  = 4'b1000;
  localparam [3:0] RX_IDLE  = 4'b0001;
  localparam [3:0] RX_START = 4'b0010;
  localparam [3:0] RX_DATA  = 4'b0100;
  localparam [3:0] RX_STOP  = 4'b1000;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [3:0] frame_bits;
    input [7:0] lc;
    begin
      frame_bits = 4'h5 + {2'b00, lc[`UADP_LC_WLEN_HI:`UADP_LC_WLEN_LO]}
                   + {3'b000, lc[`UADP_LC_PAR_EN]};
    end
  endfunction

  function par_bit;
    input [7:0] d;
    input [7:0] lc;
    begin
      par_bit = ^d ^ ~lc[`UADP_LC_PAR_EVEN];
    end
  endfunction

  function [7:0] width_mask;
    input [7:0] lc;
    begin
      width_mask = 8'hFF >> (2'h3 - lc[`UADP_LC_WLEN_HI:`UADP_LC_WLEN_LO]);
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0]  int_en_q;
  reg  [7:0]  fifo_ctl_q;
  reg  [7:0]  line_q;
  reg  [15:0] div_q;
  reg  [7:0]  scratch_q;
  reg  [1:0]  int_st_q;
  reg  [1:0]  int_msk_q;
  reg  [15:0] baud_cnt_q;
  reg         baud_tick_q;
  reg         rx_clk_q;
  reg  [3:0]  tx_state_q;
  reg  [3:0]  tx_ovs_q;
  reg  [3:0]  tx_bit_q;
  reg  [8:0]  tx_shift_q;
  reg         tx_stop2_q;
  reg  [3:0]  rx_state_q;
  reg  [3:0]  rx_ovs_q;
  reg  [3:0]  rx_bit_q;
  reg  [8:0]  rx_shift_q;
  reg         rx_push_q;
  reg  [7:0]  rx_word_q;
  reg  [4:0]  rx_cnt_prev_q;
  reg         tx_empty_prev_q;

  wire        wr_data;
  wire        rd_data;
  wire        fifo_mode;
  wire [7:0]  tx_head;
  wire [4:0]  tx_count;
  wire [7:0]  rx_head;
  wire [4:0]  rx_count;
  wire        tx_pop;
  wire        rx_tick;
  wire        tx_empty;
  wire        rx_avail;
  wire        rx_event;
  wire        tx_event;
  wire [8:0]  rx_aligned;
  reg  [4:0]  rx_level;
  reg  [7:0]  rdata_d;

  assign wr_data   = I_WR && (I_ADDR == `UADP_ADDR_DATA);
  assign rd_data   = I_RD && (I_ADDR == `UADP_ADDR_DATA);
  assign fifo_mode = fifo_ctl_q[`UADP_FC_ENABLE];
  assign tx_empty  = (tx_count == 5'h00);
  assign rx_avail  = (rx_count != 5'h00);
  // receive clock input is a 16x clock whose rising edges are detected on the master clock
  assign rx_tick   = I_RX_CLK16 && !rx_clk_q;
  assign tx_pop    = (tx_state_q == TX_IDLE) && baud_tick_q && !tx_empty;
  assign rx_aligned = (rx_shift_q >> (4'h9 - frame_bits(line_q)))
                      & {1'b0, width_mask(line_q)};

  uadp_fifo u_tx_fifo (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_flush (1'b0),
    .i_push  (wr_data),
    .i_data  (I_WDATA),
    .i_pop   (tx_pop),
    .o_data  (tx_head),
    .o_count (tx_count)
  );

  uadp_fifo u_rx_fifo (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_flush (1'b0),
    .i_push  (rx_push_q),
    .i_data  (rx_word_q),
    .i_pop   (rd_data),
    .o_data  (rx_head),
    .o_count (rx_count)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      int_en_q   <= 8'h00;
      fifo_ctl_q <= 8'h00;
      line_q     <= `UADP_LINE_RESET;
      div_q      <= `UADP_DIV_RESET;
      scratch_q  <= 8'h00;
      int_msk_q  <= 2'h0;
    end else if (I_WR) begin
      case (I_ADDR)
        `UADP_ADDR_INT_EN:  int_en_q   <= I_WDATA;
        `UADP_ADDR_FIFO:    fifo_ctl_q <= I_WDATA;
        `UADP_ADDR_LINE:    line_q     <= I_WDATA;
        `UADP_ADDR_DIV_LO:  div_q[7:0]  <= I_WDATA;
        `UADP_ADDR_DIV_HI:  div_q[15:8] <= I_WDATA;
        `UADP_ADDR_SCRATCH: scratch_q  <= I_WDATA;
        `UADP_ADDR_INT_MSK: int_msk_q  <= I_WDATA[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // a zero divisor is treated as one so the tick never stops
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      baud_cnt_q       <= `UADP_DIV_RESET;
      baud_tick_q      <= 1'b0;
      O_BAUD_CLOCK_OUT <= 1'b0;
    end else if (I_WR && (I_ADDR == `UADP_ADDR_DIV_LO)) begin
      baud_cnt_q  <= {div_q[15:8], I_WDATA};
      baud_tick_q <= 1'b0;
    end else if (I_WR && (I_ADDR == `UADP_ADDR_DIV_HI)) begin
      baud_cnt_q  <= {I_WDATA, div_q[7:0]};
      baud_tick_q <= 1'b0;
    end else if (baud_cnt_q <= 16'h0001) begin
      baud_cnt_q       <= div_q;
      baud_tick_q      <= 1'b1;
      O_BAUD_CLOCK_OUT <= 1'b1;
    end else begin
      baud_cnt_q       <= baud_cnt_q - 16'h0001;
      baud_tick_q      <= 1'b0;
      // high for the first half of the period, a single cycle for small divisors
      O_BAUD_CLOCK_OUT <= (baud_cnt_q > div_q - {1'b0, div_q[15:1]} + 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      tx_state_q      <= TX_IDLE;
      tx_ovs_q        <= 4'h0;
      tx_bit_q        <= 4'h0;
      tx_shift_q      <= 9'h1FF;
      tx_stop2_q      <= 1'b0;
      O_SERIAL_OUTPUT <= 1'b1;
    end else if (baud_tick_q) begin
      tx_ovs_q <= tx_ovs_q + 4'h1;
      case (tx_state_q)
        TX_IDLE: begin
          O_SERIAL_OUTPUT <= 1'b1;
          tx_ovs_q        <= 4'h0;
          if (tx_pop) begin
            tx_shift_q <= {1'b1, tx_head & width_mask(line_q)};
            if (line_q[`UADP_LC_PAR_EN]) begin
              tx_shift_q[4'h5 + {2'b00, line_q[1:0]}] <= par_bit(tx_head & width_mask(line_q),
                                                                line_q);
            end
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          O_SERIAL_OUTPUT <= 1'b0;
          if (tx_ovs_q == `UADP_OVS) begin
            tx_state_q <= TX_DATA;
            tx_bit_q   <= 4'h0;
          end
        end
        TX_DATA: begin
          O_SERIAL_OUTPUT <= tx_shift_q[0];
          if (tx_ovs_q == `UADP_OVS) begin
            tx_shift_q <= {1'b1, tx_shift_q[8:1]};
            tx_bit_q   <= tx_bit_q + 4'h1;
            if (tx_bit_q == frame_bits(line_q) - 4'h1) begin
              tx_state_q <= TX_STOP;
              tx_stop2_q <= line_q[`UADP_LC_STOP];
            end
          end
        end
        TX_STOP: begin
          O_SERIAL_OUTPUT <= 1'b1;
          if (tx_ovs_q == `UADP_OVS) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      rx_clk_q   <= 1'b0;
      rx_state_q <= RX_IDLE;
      rx_ovs_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_push_q  <= 1'b0;
      rx_word_q  <= 8'h00;
    end else begin
      rx_clk_q  <= I_RX_CLK16;
      rx_push_q <= 1'b0;
      if (rx_tick) begin
        rx_ovs_q <= rx_ovs_q + 4'h1;
        case (rx_state_q)
          RX_IDLE: begin
            rx_ovs_q <= 4'h0;
            if (!I_SERIAL_INPUT) begin
              rx_state_q <= RX_START;
            end
          end
          RX_START: begin
            // a glitch shorter than half a bit is rejected as false start
            if (rx_ovs_q == `UADP_OVS_MID) begin
              rx_ovs_q <= 4'h0;
              rx_bit_q <= 4'h0;
              rx_state_q <= I_SERIAL_INPUT ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_ovs_q == `UADP_OVS) begin
              rx_shift_q <= {I_SERIAL_INPUT, rx_shift_q[8:1]};
              rx_bit_q   <= rx_bit_q + 4'h1;
              if (rx_bit_q == frame_bits(line_q) - 4'h1) begin
                rx_state_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_ovs_q == `UADP_OVS) begin
              rx_state_q <= RX_IDLE;
              rx_push_q  <= 1'b1;
              rx_word_q  <= rx_aligned[7:0];
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts and read port
  // ----------------------------------------------------------------
  always @* begin
    case (fifo_ctl_q[`UADP_FC_RX_LVL_HI:`UADP_FC_RX_LVL_LO])
      2'b00:   rx_level = 5'h01;
      2'b01:   rx_level = 5'h04;
      2'b10:   rx_level = 5'h08;
      default: rx_level = 5'h0E;
    endcase
  end

  // char mode: buffer goes from empty to holding data; fifo mode: trigger level reached
  assign rx_event = fifo_mode ? (rx_count >= rx_level && rx_cnt_prev_q < rx_level)
                              : (rx_count != 5'h00 && rx_cnt_prev_q == 5'h00);
  assign tx_event = tx_empty && !tx_empty_prev_q;

  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      int_st_q        <= 2'h0;
      rx_cnt_prev_q   <= 5'h00;
      tx_empty_prev_q <= 1'b0;
      O_IRQ           <= 1'b0;
    end else begin
      rx_cnt_prev_q   <= rx_count;
      tx_empty_prev_q <= tx_empty;
      // set wins over software clear
      int_st_q[0] <= (rx_event && int_en_q[`UADP_IE_RX]) ||
                     (int_st_q[0] && !(I_WR && I_ADDR == `UADP_ADDR_INT_ST && I_WDATA[0])
                      && !(rd_data && !fifo_mode));
      int_st_q[1] <= (tx_event && int_en_q[`UADP_IE_TX]) ||
                     (int_st_q[1] && !(I_WR && I_ADDR == `UADP_ADDR_INT_ST && I_WDATA[1])
                      && !(wr_data && !fifo_mode));
      O_IRQ <= |(int_st_q & int_msk_q);
    end
  end

  always @* begin
    case (I_ADDR)
      `UADP_ADDR_DATA:    rdata_d = rx_head;
      `UADP_ADDR_INT_EN:  rdata_d = int_en_q;
      `UADP_ADDR_FIFO:    rdata_d = fifo_ctl_q;
      `UADP_ADDR_LINE:    rdata_d = line_q;
      `UADP_ADDR_DIV_LO:  rdata_d = div_q[7:0];
      `UADP_ADDR_DIV_HI:  rdata_d = div_q[15:8];
      `UADP_ADDR_STATUS:  rdata_d = {1'b0, tx_empty && tx_state_q == TX_IDLE, tx_empty,
                                     4'h0, rx_avail};
      `UADP_ADDR_SCRATCH: rdata_d = scratch_q;
      `UADP_ADDR_INT_ST:  rdata_d = {6'h00, int_st_q};
      `UADP_ADDR_INT_MSK: rdata_d = {6'h00, int_msk_q};
      default:            rdata_d = 8'h00;
    endcase
  end

  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= rdata_d;
    end else begin
      O_RDATA <= 8'h00;
    end
  end
endmodule

//--- verif/uadp_checker.sv
// assertions on register port, interrupt and serial line timing of the uart data path
`include "uadp_defines.vh"
module uadp_checker (
  input wire       I_MCLK,
  input wire       I_RESET,
  input wire [3:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire       I_WR,
  input wire       I_RD,
  input wire [7:0] O_RDATA,
  input wire       O_SERIAL_OUTPUT,
  input wire       O_BAUD_CLOCK_OUT,
  input wire       O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  scr_q;
  logic [7:0]  msk_q;
  logic [15:0] div_q;

  // ----------------------------------------
  // shadow of the written registers
  // ----------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      scr_q <= 8'h00;
      msk_q <= 8'h00;
      div_q <= 16'h0001;
    end else if (I_WR) begin
      if (I_ADDR == `UADP_ADDR_SCRATCH) scr_q <= I_WDATA;
      if (I_ADDR == `UADP_ADDR_INT_MSK) msk_q <= I_WDATA;
      if (I_ADDR == `UADP_ADDR_DIV_LO) div_q[7:0] <= I_WDATA;
      if (I_ADDR == `UADP_ADDR_DIV_HI) div_q[15:8] <= I_WDATA;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  // one bit at divisor one is sixteen cycles
  sequence low_bit;
    ##1 !O_SERIAL_OUTPUT [*7] ##1 !O_SERIAL_OUTPUT [*8];
  endsequence
  sequence high_bit;
    ##1 O_SERIAL_OUTPUT [*7] ##1 O_SERIAL_OUTPUT [*8];
  endsequence
  // a divisor of three gives one high cycle in three
  sequence pulse_of_three;
    !O_BAUD_CLOCK_OUT ##1 !O_BAUD_CLOCK_OUT ##1 O_BAUD_CLOCK_OUT;
  endsequence

  scratch_rd_a: assert property (I_RD && I_ADDR == `UADP_ADDR_SCRATCH
      |=> O_RDATA == scr_q)
    else $error("scratch read differs from last write");
  unmapped_rd_a: assert property (I_RD && I_ADDR > 4'h9 |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  reset_idle_a: assert property (disable iff (1'b0) I_RESET
      |=> O_SERIAL_OUTPUT && !O_IRQ)
    else $error("outputs not idle after reset");
  irq_masked_a: assert property (msk_q == 8'h00 && $past(msk_q) == 8'h00
      |-> !O_IRQ)
    else $error("interrupt raised while fully masked");
  start_len_a: assert property (div_q == 16'h0001 && $fell(O_SERIAL_OUTPUT) |-> low_bit)
    else $error("low bit shorter than sixteen cycles");
  high_len_a: assert property (div_q == 16'h0001 && $rose(O_SERIAL_OUTPUT) |-> high_bit)
    else $error("high bit shorter than sixteen cycles");
  // a divisor rewrite inside the window restarts the count, so it excuses the pattern
  baud_period_a: assert property (div_q == 16'h0003 && $past(div_q) == 16'h0003
      && $rose(O_BAUD_CLOCK_OUT)
      |=> ((!O_BAUD_CLOCK_OUT ##1 !O_BAUD_CLOCK_OUT ##1 O_BAUD_CLOCK_OUT)
           or (##[0:2] div_q != 16'h0003)))
    else $error("baud pulse period not three");
  div_reload_a: assert property (I_WR && I_ADDR == `UADP_ADDR_DIV_LO && I_WDATA == 8'h03
      && div_q[15:8] == 8'h00
      |-> ##2 pulse_of_three)
    else $error("baud counter not reloaded");
endmodule

//--- verif/uadp_serial_peer.sv
// serial peer: free-running receive clock, frame sender and frame monitor
module uadp_serial_peer (
  input  wire  i_clk,
  input  wire  i_line,
  output logic o_line,
  output wire  o_rx_clk16
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_q = 2'b00;
  initial o_line = 1'b1;

  // ----------------------------------------
  // four cycles a tick, so one bit is 64 cycles
  // ----------------------------------------
  always @(posedge i_clk) tick_q <= tick_q + 2'd1;
  assign o_rx_clk16 = tick_q[1];

  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_line <= f[i];
      repeat (64) @(posedge i_clk);
    end
    repeat (16) @(posedge i_clk);
  endtask

  // samples mid-bit; gives up after 400 idle cycles
  task automatic recv_byte(input int div, input int nbits, output logic [7:0] d,
                           output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    ok = 1'b0;
    while (i_line === 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    if (n < 400) begin
      repeat (8 * div) @(posedge i_clk);
      ok = (i_line === 1'b0);
      for (int i = 0; i < nbits; i++) begin
        repeat (16 * div) @(posedge i_clk);
        d[i] = i_line;
      end
      repeat (16 * div) @(posedge i_clk);
      ok = ok & (i_line === 1'b1);
    end
  endtask
endmodule

//--- verif/test_uart_data_path_fifo.sv
// self-checking bench of the uart data path
`include "uadp_defines.vh"
module test_uart_data_path_fifo;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'b0;
  logic       reset;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  wire        rx_clk16;
  wire        ser_in;
  wire  [7:0] rdata;
  wire        ser_out;
  wire        baud_out;
  wire        irq;
  logic [7:0] v;
  logic [7:0] b;
  logic       ok;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles = 0;

  always #20 mclk = ~mclk;

  uadp_top DUT (.I_MCLK(mclk), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_RX_CLK16(rx_clk16), .I_SERIAL_INPUT(ser_in), .O_RDATA(rdata),
    .O_SERIAL_OUTPUT(ser_out), .O_BAUD_CLOCK_OUT(baud_out), .O_IRQ(irq));
  uadp_serial_peer peer (.i_clk(mclk), .i_line(ser_out), .o_line(ser_in),
    .o_rx_clk16(rx_clk16));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // lands off the edge so registered outputs are settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(`UADP_ADDR_SCRATCH, v);
    chk("scratch reset", v, 8'h00);
    rd_reg(`UADP_ADDR_LINE, v);
    chk("line reset", v, `UADP_LINE_RESET);
    rd_reg(4'hC, v);
    chk("unmapped", v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`UADP_ADDR_SCRATCH, 8'(8'h55 * i));
      rd_reg(`UADP_ADDR_SCRATCH, v);
      chk("scratch", v, 8'(8'h55 * i));
      rd_reg(`UADP_ADDR_LINE, v);
      chk("line kept", v, `UADP_LINE_RESET);
    end
    chk("line idle", ser_out, 8'h01);
    // shifter plus sixteen held bytes; the eighteenth is dropped
    wr_reg(`UADP_ADDR_FIFO, 8'h01);
    fork
      for (int i = 0; i < 18; i++) wr_reg(`UADP_ADDR_DATA, 8'(8'h30 + i));
      for (int i = 0; i < 17; i++) begin
        peer.recv_byte(1, 8, b, ok);
        chk("tx frame", ok, 8'h01);
        chk("tx data", b, 8'(8'h30 + i));
      end
    join
    peer.recv_byte(1, 8, b, ok);
    chk("tx dropped", ok, 8'h00);
    wr_reg(`UADP_ADDR_DIV_LO, 8'h03);
    wr_reg(`UADP_ADDR_LINE, 8'h02);
    fork
      wr_reg(`UADP_ADDR_DATA, 8'hD6);
      peer.recv_byte(3, 7, b, ok);
    join
    chk("slow frame", ok, 8'h01);
    chk("seven bits", b, 8'h56);
    wait_cyc(48);
    // seven bits plus odd parity arrive as an eight-bit word
    wr_reg(`UADP_ADDR_LINE, 8'h0A);
    fork
      wr_reg(`UADP_ADDR_DATA, 8'hD6);
      peer.recv_byte(3, 8, b, ok);
    join
    chk("parity frame", ok, 8'h01);
    chk("odd parity", b, 8'hD6);
    wait_cyc(48);
    wr_reg(`UADP_ADDR_LINE, `UADP_LINE_RESET);
    wr_reg(`UADP_ADDR_DIV_LO, 8'h01);
    for (int i = 0; i < 16; i++) peer.send_byte(8'(8'hC0 + i));
    rd_reg(`UADP_ADDR_STATUS, v);
    chk("rx avail", v & 8'h61, 8'h61);
    for (int i = 0; i < 16; i++) begin
      rd_reg(`UADP_ADDR_DATA, v);
      chk("rx data", v, 8'(8'hC0 + i));
    end
    rd_reg(`UADP_ADDR_STATUS, v);
    chk("rx empty", v & 8'h01, 8'h00);
    wr_reg(`UADP_ADDR_FIFO, 8'h00);
    wr_reg(`UADP_ADDR_INT_ST, 8'h03);
    wr_reg(`UADP_ADDR_INT_MSK, 8'h03);
    wr_reg(`UADP_ADDR_INT_EN, 8'h01);
    peer.send_byte(8'h5A);
    wait_cyc(1);
    chk("rx irq", irq, 8'h01);
    rd_reg(`UADP_ADDR_DATA, v);
    chk("rx char", v, 8'h5A);
    wait_cyc(2);
    chk("rx irq clear", irq, 8'h00);
    wr_reg(`UADP_ADDR_INT_MSK, 8'h00);
    peer.send_byte(8'h11);
    wait_cyc(1);
    chk("masked", irq, 8'h00);
    rd_reg(`UADP_ADDR_INT_ST, v);
    chk("rx pending", v & 8'h01, 8'h01);
    wr_reg(`UADP_ADDR_INT_MSK, 8'h01);
    wait_cyc(2);
    chk("unmasked", irq, 8'h01);
    wr_reg(`UADP_ADDR_INT_ST, 8'h01);
    wait_cyc(2);
    chk("w1c", irq, 8'h00);
    rd_reg(`UADP_ADDR_DATA, v);
    chk("rx char", v, 8'h11);
    wr_reg(`UADP_ADDR_INT_EN, 8'h02);
    wr_reg(`UADP_ADDR_INT_MSK, 8'h02);
    wr_reg(`UADP_ADDR_DATA, 8'h77);
    wait_cyc(8);
    chk("tx irq", irq, 8'h01);
    wr_reg(`UADP_ADDR_DATA, 8'h88);
    wait_cyc(2);
    chk("tx irq clear", irq, 8'h00);
    wait_cyc(200);
    chk("tx irq again", irq, 8'h01);
    wr_reg(`UADP_ADDR_INT_ST, 8'h02);
    wait_cyc(200);
    wr_reg(`UADP_ADDR_INT_EN, 8'h01);
    wr_reg(`UADP_ADDR_INT_MSK, 8'h01);
    wr_reg(`UADP_ADDR_FIFO, 8'h41);
    for (int i = 0; i < 3; i++) peer.send_byte(8'(i));
    wait_cyc(1);
    chk("below level", irq, 8'h00);
    peer.send_byte(8'h03);
    wait_cyc(1);
    chk("at level", irq, 8'h01);
    rd_reg(`UADP_ADDR_DATA, v);
    wait_cyc(2);
    chk("fifo irq held", irq, 8'h01);
    wr_reg(`UADP_ADDR_INT_ST, 8'h01);
    wait_cyc(2);
    chk("fifo irq clear", irq, 8'h00);
    end_of_test();
  end
endmodule

bind uadp_top uadp_checker u_checker (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_SERIAL_OUTPUT(O_SERIAL_OUTPUT), .O_BAUD_CLOCK_OUT(O_BAUD_CLOCK_OUT), .O_IRQ(O_IRQ));
